// ==== lcr_pkg.sv ====
// Notes on behaviour
// - Bit0 register one enables overcurrent detection, default off
// - Bit1 picks resistor oscillator or external clock
// - Bit2 picks internal or external lamp sync
// - Bit3 picks internal or external dimming sync
// - Bit4 puts ramp or burst signal out
// - Bit5 set suppresses automatic retry after faults
// - Bit7 set switches burst dimming off
// - Register two bit0 permits user memory writes
// - Range codes give scaling 1, 2, 4, 8
// - Sample rate bits 3,4, low default one
// - Sample every 4, 8, 16, 32 cycles
`default_nettype none
package lcr_pkg;
    localparam logic [7:0] LAMP_SOURCE_CONTROL_ADDR = 8'hf4;
    localparam logic [7:0] DIMMING_MEMORY_CONTROL_ADDR = 8'hf5;
    localparam logic [7:0] LAMP_SOURCE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] DIMMING_MEMORY_CONTROL_RESET = 8'h08;
    localparam logic [7:0] DIMMING_MEMORY_CONTROL_MASK = 8'h1f;
    // Fields of lamp_source_control
    localparam int OVERCURRENT_DETECT_ENABLE_BIT = 0;
    localparam int DIM_OSC_INPUT_SELECT_BIT = 1;
    localparam int LAMP_FREQ_SOURCE_SELECT_BIT = 2;
    localparam int BURST_DIM_SOURCE_SELECT_BIT = 3;
    localparam int RAMP_OUTPUT_OPTION_BIT = 4;
    localparam int AUTORETRY_DISABLE_BIT = 5;
    localparam int BURST_DIM_DISABLE_BIT = 7;
    // Fields of dimming_memory_control
    localparam int USER_MEM_WRITE_PROTECT_BIT = 0;
    localparam int DIM_OSC_RANGE_LO_BIT = 1;
    localparam int DIM_OSC_RANGE_HI_BIT = 2;
    localparam int SAMPLE_RATE_LO_BIT = 3;
    localparam int SAMPLE_RATE_HI_BIT = 4;
    // Sampling interval in lamp cycles, minus one, per code
    localparam logic [4:0] SAMPLE_LAST_CODE0 = 5'h03;
    localparam logic [4:0] SAMPLE_LAST_CODE1 = 5'h07;
    localparam logic [4:0] SAMPLE_LAST_CODE2 = 5'h0f;
    localparam logic [4:0] SAMPLE_LAST_CODE3 = 5'h1f;
    // Oscillator scaling constant, kilohm times kilohertz
    localparam logic [3:0] DIM_OSC_SCALE_CODE0 = 4'h1;
    localparam logic [3:0] DIM_OSC_SCALE_CODE1 = 4'h2;
    localparam logic [3:0] DIM_OSC_SCALE_CODE2 = 4'h4;
    localparam logic [3:0] DIM_OSC_SCALE_CODE3 = 4'h8;
endpackage
`default_nettype wire

// ==== lcr_regs.sv ====
`default_nettype none
module lcr_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic int_lamp_clk,
    input wire logic lamp_sync_pin_in,
    output logic lamp_sync_pin_out,
    output logic lamp_sync_pin_oe,
    input wire logic int_burst_dim,
    input wire logic int_ramp,
    input wire logic dim_sync_pin_in,
    output logic dim_sync_pin_out,
    output logic dim_sync_pin_oe,
    input wire logic overcurrent_raw,
    input wire logic user_mem_wr_req,
    output logic overcurrent_detect_enable,
    output logic overcurrent_fault,
    output logic dim_osc_input_select,
    output logic [3:0] dim_osc_scale,
    output logic lamp_freq_source_select,
    output logic burst_dim_source_select,
    output logic burst_dimming,
    output logic autoretry_enable,
    output logic user_mem_wr_en,
    output logic lamp_cycle,
    output logic lamp_current_feedback_sample
);
    typedef enum logic {LCR_IDLE, LCR_READ} lcr_rd_t;

    logic [7:0] lamp_source_control;
    logic [7:0] dimming_memory_control;
    lcr_rd_t rd_state;
    logic lamp_clk_prev;
    logic [4:0] sample_count;

    // Address decode
    wire sel_lsc = reg_addr == lcr_pkg::LAMP_SOURCE_CONTROL_ADDR;
    wire sel_dmc = reg_addr == lcr_pkg::DIMMING_MEMORY_CONTROL_ADDR;
    wire wr_lsc = reg_wr && sel_lsc;
    wire wr_dmc = reg_wr && sel_dmc;
    // Unmapped addresses read as zero
    wire [7:0] rd_mux = sel_lsc ? lamp_source_control :
                        sel_dmc ? dimming_memory_control : 8'h00;

    // Field views
    wire f_ocd = lamp_source_control[lcr_pkg::OVERCURRENT_DETECT_ENABLE_BIT];
    wire f_osc_sel = lamp_source_control[lcr_pkg::DIM_OSC_INPUT_SELECT_BIT];
    wire f_lamp_freq_source_select = lamp_source_control[lcr_pkg::LAMP_FREQ_SOURCE_SELECT_BIT];
    wire f_burst_dim_source_select = lamp_source_control[lcr_pkg::BURST_DIM_SOURCE_SELECT_BIT];
    wire f_ramp = lamp_source_control[lcr_pkg::RAMP_OUTPUT_OPTION_BIT];
    wire f_ard = lamp_source_control[lcr_pkg::AUTORETRY_DISABLE_BIT];
    wire f_dpd = lamp_source_control[lcr_pkg::BURST_DIM_DISABLE_BIT];
    wire f_user_mem_write_protect = dimming_memory_control[lcr_pkg::USER_MEM_WRITE_PROTECT_BIT];
    wire [1:0] f_range = {dimming_memory_control[lcr_pkg::DIM_OSC_RANGE_HI_BIT],
                          dimming_memory_control[lcr_pkg::DIM_OSC_RANGE_LO_BIT]};
    wire [1:0] f_rate = {dimming_memory_control[lcr_pkg::SAMPLE_RATE_HI_BIT],
                         dimming_memory_control[lcr_pkg::SAMPLE_RATE_LO_BIT]};

    wire [3:0] next_dim_osc_scale = (f_range == 2'h0) ? lcr_pkg::DIM_OSC_SCALE_CODE0 :
                                    (f_range == 2'h1) ? lcr_pkg::DIM_OSC_SCALE_CODE1 :
                                    (f_range == 2'h2) ? lcr_pkg::DIM_OSC_SCALE_CODE2 :
                                    lcr_pkg::DIM_OSC_SCALE_CODE3;

    wire [4:0] sample_last = (f_rate == 2'h0) ? lcr_pkg::SAMPLE_LAST_CODE0 :
                             (f_rate == 2'h1) ? lcr_pkg::SAMPLE_LAST_CODE1 :
                             (f_rate == 2'h2) ? lcr_pkg::SAMPLE_LAST_CODE2 :
                             lcr_pkg::SAMPLE_LAST_CODE3;

    wire lamp_clk_sel = f_lamp_freq_source_select ? lamp_sync_pin_in : int_lamp_clk;
    wire lamp_tick = lamp_clk_sel && !lamp_clk_prev;
    // Wrap also when a shorter code is written mid-count
    wire sample_wrap = lamp_tick && (sample_count >= sample_last);
    wire [4:0] next_sample_count = !lamp_tick ? sample_count :
                                   sample_wrap ? 5'h00 : sample_count + 5'h01;

    wire dim_sel = f_burst_dim_source_select ? dim_sync_pin_in : int_burst_dim;
    // ramp or burst on sync output
    wire next_dim_out = f_ramp ? int_ramp : int_burst_dim;

    // Register writes; reserved bit kept as written, host must keep it zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            lamp_source_control <= lcr_pkg::LAMP_SOURCE_CONTROL_RESET;
            dimming_memory_control <= lcr_pkg::DIMMING_MEMORY_CONTROL_RESET;
        end else begin
            if (wr_lsc) begin
                lamp_source_control <= reg_wdata;
            end
            if (wr_dmc) begin
                dimming_memory_control <= reg_wdata & lcr_pkg::DIMMING_MEMORY_CONTROL_MASK;
            end
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_state <= LCR_IDLE;
            reg_rdata <= 8'h00;
        end else begin
            case (rd_state)
                LCR_IDLE: begin
                    if (reg_rd) begin
                        rd_state <= LCR_READ;
                        reg_rdata <= rd_mux;
                    end
                end
                LCR_READ: begin
                    rd_state <= reg_rd ? LCR_READ : LCR_IDLE;
                    reg_rdata <= reg_rd ? rd_mux : reg_rdata;
                end
                default: begin
                    rd_state <= LCR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            overcurrent_detect_enable <= 1'b0;
            overcurrent_fault <= 1'b0;
            dim_osc_input_select <= 1'b0;
            dim_osc_scale <= lcr_pkg::DIM_OSC_SCALE_CODE0;
            lamp_freq_source_select <= 1'b0;
            burst_dim_source_select <= 1'b0;
            autoretry_enable <= 1'b1;
            user_mem_wr_en <= 1'b0;
        end else begin
            overcurrent_detect_enable <= f_ocd;
            overcurrent_fault <= f_ocd && overcurrent_raw;
            dim_osc_input_select <= f_osc_sel;
            dim_osc_scale <= next_dim_osc_scale;
            lamp_freq_source_select <= f_lamp_freq_source_select;
            burst_dim_source_select <= f_burst_dim_source_select;
            autoretry_enable <= !f_ard;
            user_mem_wr_en <= f_user_mem_write_protect && user_mem_wr_req;
        end
    end

    // Pin drive and burst dimming path
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            lamp_sync_pin_out <= 1'b0;
            lamp_sync_pin_oe <= 1'b0;
            dim_sync_pin_out <= 1'b0;
            dim_sync_pin_oe <= 1'b0;
            burst_dimming <= 1'b0;
        end else begin
            // drive lamp sync only when internal
            lamp_sync_pin_out <= int_lamp_clk;
            lamp_sync_pin_oe <= !f_lamp_freq_source_select;
            // drive dimming sync only when internal
            dim_sync_pin_out <= next_dim_out;
            dim_sync_pin_oe <= !f_burst_dim_source_select;
            burst_dimming <= !f_dpd && dim_sel;
        end
    end

    // lamp cycle counter for feedback sampling
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            lamp_clk_prev <= 1'b0;
            sample_count <= 5'h00;
            lamp_cycle <= 1'b0;
            lamp_current_feedback_sample <= 1'b0;
        end else begin
            lamp_clk_prev <= lamp_clk_sel;
            sample_count <= next_sample_count;
            lamp_cycle <= lamp_tick;
            lamp_current_feedback_sample <= sample_wrap;
        end
    end

    // Assertions
    sequence s_wr_lsc;
        wr_lsc;
    endsequence
    sequence s_wr_dmc;
        wr_dmc;
    endsequence

    property p_ocd_follow;
        @(posedge core_clk) disable iff (!rstn)
        s_wr_lsc ##2 1'b1 |-> overcurrent_detect_enable == $past(reg_wdata[0], 2);
    endproperty
    a_ocd_follow: assert property (p_ocd_follow) else $error("overcurrent enable lag");

    property p_ocd_gate;
        @(posedge core_clk) disable iff (!rstn)
        overcurrent_fault |-> $past(overcurrent_raw) && $past(f_ocd);
    endproperty
    a_ocd_gate: assert property (p_ocd_gate) else $error("fault while disabled");

    property p_osc_sel;
        @(posedge core_clk) disable iff (!rstn)
        s_wr_lsc ##2 1'b1 |-> dim_osc_input_select == $past(reg_wdata[1], 2);
    endproperty
    a_osc_sel: assert property (p_osc_sel) else $error("oscillator select lag");

    property p_lamp_oe;
        @(posedge core_clk) disable iff (!rstn)
        s_wr_lsc ##2 1'b1 |-> lamp_sync_pin_oe == !$past(reg_wdata[2], 2);
    endproperty
    a_lamp_oe: assert property (p_lamp_oe) else $error("lamp sync drive wrong");

    property p_dim_oe;
        @(posedge core_clk) disable iff (!rstn)
        s_wr_lsc ##2 1'b1 |-> dim_sync_pin_oe == !$past(reg_wdata[3], 2);
    endproperty
    a_dim_oe: assert property (p_dim_oe) else $error("dim sync drive wrong");

    property p_ramp_out;
        @(posedge core_clk) disable iff (!rstn)
        $past(f_ramp) && $past(rstn) |-> dim_sync_pin_out == $past(int_ramp);
    endproperty
    a_ramp_out: assert property (p_ramp_out) else $error("ramp not on sync");

    property p_retry;
        @(posedge core_clk) disable iff (!rstn)
        s_wr_lsc ##2 1'b1 |-> autoretry_enable == !$past(reg_wdata[5], 2);
    endproperty
    a_retry: assert property (p_retry) else $error("autoretry wrong");

    property p_dpd;
        @(posedge core_clk) disable iff (!rstn)
        $past(f_dpd) |-> !burst_dimming;
    endproperty
    a_dpd: assert property (p_dpd) else $error("burst active when off");

    property p_user_mem_write_protect;
        @(posedge core_clk) disable iff (!rstn)
        user_mem_wr_en |-> $past(f_user_mem_write_protect) && $past(user_mem_wr_req);
    endproperty
    a_user_mem_write_protect: assert property (p_user_mem_write_protect) else $error("protected write passed");

    property p_scale;
        @(posedge core_clk) disable iff (!rstn)
        s_wr_dmc ##2 1'b1 |-> dim_osc_scale == (4'h1 << $past(reg_wdata[2:1], 2));
    endproperty
    a_scale: assert property (p_scale) else $error("scale constant wrong");

    property p_rate_reset;
        @(posedge core_clk)
        $rose(rstn) |-> f_rate == 2'h1;
    endproperty
    a_rate_reset: assert property (p_rate_reset) else $error("sample rate default");

    property p_interval;
        @(posedge core_clk) disable iff (!rstn)
        lamp_tick |-> sample_wrap == ({1'b0, sample_count} >= ((6'h04 << f_rate) - 6'h01));
    endproperty
    a_interval: assert property (p_interval) else $error("sample interval wrong");

    property p_next_cycle;
        @(posedge core_clk) disable iff (!rstn)
        s_wr_dmc ##1 1'b1 |->
            dimming_memory_control == ($past(reg_wdata) & lcr_pkg::DIMMING_MEMORY_CONTROL_MASK);
    endproperty
    a_next_cycle: assert property (p_next_cycle) else $error("write not stored");
endmodule
`default_nettype wire

// ==== lcr_host.sv ====
`default_nettype none
module lcr_host (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Strobes low from time zero so nothing is taken during reset
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One byte written; held until the taking edge has passed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = (a == lcr_pkg::LAMP_SOURCE_CONTROL_ADDR) ? (d & 8'hbf) : d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata; // Stale data never looks valid
    endtask
    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        @(posedge core_clk);
        #1;
        d = reg_rdata;
    endtask
    function automatic logic [1:0] ext_range(input int hz_x10);
        return (hz_x10 <= 550) ? 2'h0 : (hz_x10 <= 1100) ? 2'h1 : (hz_x10 <= 2200) ? 2'h2 : 2'h3;
    endfunction
endmodule
`default_nettype wire

// ==== lamp_controller_config_regs_tb.sv ====
`default_nettype none
module lamp_controller_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic reg_wr, reg_rd, lamp_sync_pin_out, lamp_sync_pin_oe, dim_sync_pin_out, dim_sync_pin_oe;
    logic int_lamp_clk = 1'b0, lamp_sync_pin_in = 1'b0, int_burst_dim = 1'b0, int_ramp = 1'b0;
    logic dim_sync_pin_in = 1'b0, overcurrent_raw = 1'b0, user_mem_wr_req = 1'b0;
    logic overcurrent_detect_enable, overcurrent_fault, dim_osc_input_select;
    logic lamp_freq_source_select, burst_dim_source_select, burst_dimming, autoretry_enable;
    logic user_mem_wr_en, lamp_cycle, lamp_current_feedback_sample;
    logic [3:0] dim_osc_scale;
    logic [15:0] outs;
    int cr1, cr2, err_count = 0, checks = 0, first, ns, nl;
    always #5 core_clk = ~core_clk;
    lcr_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    lcr_regs dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_lamp_clk(int_lamp_clk),
        .lamp_sync_pin_in(lamp_sync_pin_in), .lamp_sync_pin_out(lamp_sync_pin_out),
        .lamp_sync_pin_oe(lamp_sync_pin_oe), .int_burst_dim(int_burst_dim), .int_ramp(int_ramp),
        .dim_sync_pin_in(dim_sync_pin_in), .dim_sync_pin_out(dim_sync_pin_out),
        .dim_sync_pin_oe(dim_sync_pin_oe), .overcurrent_raw(overcurrent_raw),
        .user_mem_wr_req(user_mem_wr_req), .overcurrent_detect_enable(overcurrent_detect_enable),
        .overcurrent_fault(overcurrent_fault), .dim_osc_input_select(dim_osc_input_select),
        .dim_osc_scale(dim_osc_scale), .lamp_freq_source_select(lamp_freq_source_select),
        .burst_dim_source_select(burst_dim_source_select), .burst_dimming(burst_dimming),
        .autoretry_enable(autoretry_enable), .user_mem_wr_en(user_mem_wr_en),
        .lamp_cycle(lamp_cycle), .lamp_current_feedback_sample(lamp_current_feedback_sample));
    // All settled outputs in one vector for a single compare
    assign outs = {lamp_sync_pin_out, user_mem_wr_en, overcurrent_fault, burst_dimming,
        dim_sync_pin_out, dim_sync_pin_oe, lamp_sync_pin_oe, autoretry_enable,
        burst_dim_source_select, lamp_freq_source_select, dim_osc_scale, dim_osc_input_select,
        overcurrent_detect_enable};
    // Expected outputs from the register model and the held inputs
    function automatic logic [15:0] model_outs();
        logic [15:0] e;
        e[0] = cr1[0];
        e[1] = cr1[1];
        e[5:2] = 4'h1 << cr2[2:1];
        e[6] = cr1[2];
        e[7] = cr1[3];
        e[8] = !cr1[5];
        e[9] = !cr1[2];
        e[10] = !cr1[3];
        e[11] = cr1[4] ? int_ramp : int_burst_dim;
        e[12] = !cr1[7] && (cr1[3] ? dim_sync_pin_in : int_burst_dim);
        e[13] = overcurrent_raw && cr1[0];
        e[14] = cr2[0] && user_mem_wr_req;
        e[15] = int_lamp_clk;
        return e;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Reset held two cycles; model follows
    task automatic do_reset();
        @(posedge core_clk);
        #1;
        rstn = 1'b0;
        cycles(2);
        rstn = 1'b1;
        cr1 = 0;
        cr2 = 8;
        cycles(2);
    endtask
    // Lamp ticks two cycles high, two low; pulses counted each cycle
    task automatic run_ticks(input int n, input bit pin);
        first = 0;
        ns = 0;
        nl = 0;
        for (int c = 0; c < 4 * n + 8; c++) begin
            // external source drives the sync pin
            if (pin) lamp_sync_pin_in = (c < 4 * n) && (c % 4 < 2);
            else int_lamp_clk = (c < 4 * n) && (c % 4 < 2);
            cycles(1);
            if (lamp_cycle === 1'b1) nl++;
            if (lamp_current_feedback_sample === 1'b1) begin
                ns++;
                if (first == 0) first = nl;
            end
        end
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h91eb));
        do_reset();
        chk("reset outputs", model_outs(), outs);
        host.rd(lcr_pkg::LAMP_SOURCE_CONTROL_ADDR, rd_val);
        chk("read f4", 16'h0000, 16'(rd_val));
        host.rd(lcr_pkg::DIMMING_MEMORY_CONTROL_ADDR, rd_val);
        chk("read f5", 16'h0008, 16'(rd_val));
        host.rd(8'h37, rd_val);
        chk("read unmapped", 16'h0000, 16'(rd_val));
        $display("test reset done");
        host.wr(lcr_pkg::LAMP_SOURCE_CONTROL_ADDR, 8'h01);
        // Stored at the taking edge, output flop follows at the next edge
        chk("enable at strobe", 16'h0000, {15'h0000, overcurrent_detect_enable});
        cycles(1);
        chk("enable one later", 16'h0001, {15'h0000, overcurrent_detect_enable});
        cycles(1);
        chk("enable two later", 16'h0001, {15'h0000, overcurrent_detect_enable});
        $display("test timing done");
        for (int i = 0; i < 48; i++) begin
            cr1 = $urandom() & 8'hbf;
            cr2 = $urandom() & 8'h1f;
            if (i == 0) cr2 = {3'h0, 2'h1, host.ext_range(3000), 1'b1};
            {int_burst_dim, int_ramp, dim_sync_pin_in, overcurrent_raw} = 4'($urandom());
            {user_mem_wr_req, lamp_sync_pin_in, int_lamp_clk} = 3'($urandom());
            host.wr(lcr_pkg::LAMP_SOURCE_CONTROL_ADDR, 8'(cr1));
            host.wr(lcr_pkg::DIMMING_MEMORY_CONTROL_ADDR, 8'(cr2 | 8'he0));
            cycles(3);
            chk("control outputs", model_outs(), outs);
            host.rd(lcr_pkg::LAMP_SOURCE_CONTROL_ADDR, rd_val);
            chk("readback f4", 16'(cr1), 16'(rd_val));
            host.rd(lcr_pkg::DIMMING_MEMORY_CONTROL_ADDR, rd_val);
            chk("readback f5", 16'(cr2), 16'(rd_val));
        end
        $display("test random control done");
        {int_lamp_clk, lamp_sync_pin_in} = 2'b00;
        for (int code = 0; code < 4; code++) begin
            do_reset();
            host.wr(lcr_pkg::DIMMING_MEMORY_CONTROL_ADDR, 8'(code << 3));
            host.wr(lcr_pkg::LAMP_SOURCE_CONTROL_ADDR, 8'((code % 2) << 2));
            cycles(3);
            run_ticks(8 << code, code % 2);
            chk("first sample tick", 16'(4 << code), 16'(first));
            chk("sample count", 16'h0002, 16'(ns));
            chk("lamp cycles", 16'(8 << code), 16'(nl));
        end
        $display("test sampling done");
        stop_test();
    end
endmodule
`default_nettype wire
